// ==== rtl/rsc_pkg.sv ====
// constants and types shared by the regulator slot control register bank
// assumes a single 40 MHz clock and an axi4-lite master on the register side
package rsc_pkg;

  // ****************************************
  // register indices and address width
  // ****************************************
  // printed offsets are not multiples of four, so they are indices
  localparam logic [15:0] RSC_IDX_REG3_CTRL = 16'h406e;
  localparam logic [15:0] RSC_IDX_REG3_ON = 16'h406f;
  localparam logic [15:0] RSC_IDX_REG3_SLEEP = 16'h4070;
  localparam logic [15:0] RSC_IDX_REG4_CTRL = 16'h4071;
  localparam logic [15:0] RSC_IDX_STATUS = 16'h4074;
  localparam logic [15:0] RSC_IDX_REG4_ON = 16'h4072;
  localparam logic [15:0] RSC_IDX_REG4_SLEEP = 16'h4073;
  localparam int RSC_ADDR_W = 18;

  // ****************************************
  // field positions
  // ****************************************
  localparam int RSC_ACT_LSB = 14;
  localparam int RSC_SRC_LSB = 11;
  localparam int RSC_HVSEL_BIT = 10;
  localparam int RSC_HMODE_LSB = 8;
  localparam int RSC_FLT_BIT = 7;
  localparam int RSC_SWI_BIT = 6;
  localparam int RSC_LP_BIT = 0;
  localparam int RSC_SLOT_LSB = 13;
  localparam int RSC_MODE_BIT = 8;
  localparam int RSC_VSEL_LSB = 0;

  // writable bit masks
  localparam logic [15:0] RSC_CTRL_MASK = 16'hdfc1;
  localparam logic [15:0] RSC_ONSL_MASK = 16'he11f;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] RSC_CTRL_RST = 16'h0200;
  localparam logic [15:0] RSC_ON_RST = 16'h0000;
  localparam logic [15:0] RSC_SLEEP_RST = 16'h0100;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [1:0] RSC_HM_OFF = 2'h1;
  localparam logic [1:0] RSC_HM_FOLLOW = 2'h3;
  localparam logic [1:0] RSC_ACT_SHUT = 2'h1;
  localparam logic [1:0] RSC_ACT_RESET = 2'h2;
  localparam logic [2:0] RSC_SLOT_HWEN1 = 3'h6;
  localparam logic [2:0] RSC_SLOT_HWEN2 = 3'h7;
  localparam logic [2:0] RSC_SLOT_NONE = 3'h0;

  // axi responses
  localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;

  // per-regulator decoded control
  typedef struct packed {
    logic enable_by_slot;  // enabled in a startup slot
    logic [2:0] enable_slot;  // that startup slot, 1..5
    logic hw_enable1;  // enable follows hw enable 1
    logic hw_enable2;  // enable follows hw enable 2
    logic sleep_disable;  // sleep entry disables it
    logic [2:0] sleep_slot;  // sleep entry timeslot
  } rsc_seq_t;

endpackage

// ==== rtl/rsc_reg_side.sv ====
// per-regulator decode of sequencing and hardware-control settings
// assumes the register fields arrive straight from the register bank
`timescale 1ns/100ps
module rsc_reg_side (
  input wire logic [15:0] ctrl_word, // control register
  input wire logic [15:0] on_word, // on control register
  input wire logic [15:0] sleep_word, // sleep control register
  input wire logic in_sleep, // sequencer reports sleep state
  input wire logic hwctl1, // hardware control input 1
  input wire logic hwctl2, // hardware control input 2
  input wire logic undervoltage, // undervoltage event pulse
  output rsc_pkg::rsc_seq_t seq, // decoded slot settings
  output logic hw_active, // selected hw control asserted
  output logic reg_off, // regulator forced off
  output logic low_power, // low power mode in force
  output logic [4:0] voltage_code, // voltage code applied
  output logic shutdown_req, // regulator shutdown request
  output logic reset_req, // device reset request
  output logic irq_event // undervoltage interrupt event
);
  import rsc_pkg::*;

  // ****************************************
  // field extraction
  // ****************************************
  logic [1:0] action; // undervoltage action field
  logic [1:0] source; // hw control source
  logic [1:0] hmode; // hw control opmode
  logic [2:0] on_slot; // on timeslot
  logic [2:0] sl_slot; // sleep timeslot
  logic mode_now; // on or sleep mode bit
  logic [4:0] vsel_now; // on or sleep voltage
  logic assigned_hw; // enable owned by a hw input

  assign action = ctrl_word[RSC_ACT_LSB +: 2];
  assign source = ctrl_word[RSC_SRC_LSB +: 2];
  assign hmode = ctrl_word[RSC_HMODE_LSB +: 2];
  assign on_slot = on_word[RSC_SLOT_LSB +: 3];
  assign sl_slot = sleep_word[RSC_SLOT_LSB +: 3];

  // decode of the regulator behaviour
  always_comb begin
    hw_active = (source[0] & hwctl1) | (source[1] & hwctl2);
    mode_now = in_sleep ? sleep_word[RSC_MODE_BIT] : on_word[RSC_MODE_BIT];
    vsel_now = in_sleep ? sleep_word[RSC_VSEL_LSB +: 5]
                        : on_word[RSC_VSEL_LSB +: 5];
    reg_off = 1'b0;
    low_power = mode_now;
    voltage_code = vsel_now;
    if (hw_active) begin
      voltage_code = ctrl_word[RSC_HVSEL_BIT] ? sleep_word[RSC_VSEL_LSB +: 5]
                                              : on_word[RSC_VSEL_LSB +: 5];
      if (hmode == RSC_HM_OFF) begin
        reg_off = 1'b1;
        low_power = 1'b0;
      end else if (hmode == RSC_HM_FOLLOW) begin
        low_power = on_word[RSC_MODE_BIT];
      end else begin
        low_power = 1'b1;
      end
    end
  end

  // sequencing decode
  always_comb begin
    assigned_hw = (on_slot == RSC_SLOT_HWEN1) | (on_slot == RSC_SLOT_HWEN2);
    seq = '0;
    seq.enable_by_slot = (on_slot != RSC_SLOT_NONE) & ~assigned_hw;
    seq.enable_slot = seq.enable_by_slot ? on_slot : 3'h0;
    seq.hw_enable1 = (on_slot == RSC_SLOT_HWEN1);
    seq.hw_enable2 = (on_slot == RSC_SLOT_HWEN2);
    case (sl_slot)
      3'h0: seq.sleep_slot = 3'h5;
      3'h6: seq.sleep_slot = 3'h3;
      3'h7: seq.sleep_slot = 3'h1;
      default: seq.sleep_slot = 3'h6 - sl_slot;
    endcase
    seq.sleep_disable = (sl_slot != 3'h0) & (sl_slot < 3'h6) & ~assigned_hw;
  end

  assign irq_event = undervoltage;
  assign shutdown_req = undervoltage & (action == RSC_ACT_SHUT);
  assign reset_req = undervoltage & (action == RSC_ACT_RESET);

endmodule

// ==== rtl/rsc_regbank.sv ====
// axi4-lite register bank for regulator 3 and 4 control
// assumes axi4-lite master, synchronous inputs, single 40 MHz clock
`timescale 1ns/100ps
module rsc_regbank (
  input wire logic clk, // 40 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic [rsc_pkg::RSC_ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [rsc_pkg::RSC_ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic in_sleep, // sequencer in sleep state
  input wire logic hwctl1, // hardware control input 1
  input wire logic hwctl2, // hardware control input 2
  input wire logic reg3_undervoltage, // reg3 undervoltage pulse
  input wire logic reg4_undervoltage, // reg4 undervoltage pulse
  output rsc_pkg::rsc_seq_t reg3_seq, // reg3 slot settings
  output logic reg3_off, // reg3 forced off
  output logic reg3_low_power, // reg3 low power in force
  output logic reg3_lowpower_variant, // 0 50mA, 1 20mA
  output logic reg3_output_float, // float when disabled
  output logic reg3_switch_mode, // switch mode selected
  output logic [4:0] reg3_voltage, // reg3 applied voltage code
  output logic reg4_off, // reg4 forced off
  output logic reg4_low_power, // reg4 low power in force
  output logic [4:0] reg4_voltage, // reg4 applied voltage code
  output logic reg_shutdown3, // reg3 shutdown pulse
  output logic reg_shutdown4, // reg4 shutdown pulse
  output logic device_reset_req, // device reset pulse
  output logic undervoltage_irq // undervoltage interrupt pulse
);
  import rsc_pkg::*;

  // behaviour in brief:
  // - a write needs both halves parked; its response waits for bready
  // - a read answers one cycle after its address is taken
  // - applied regulator settings are registered one cycle late, so the
  //   analogue side never sees a half-decoded control word
  // - undervoltage events give one-cycle pulses and a sticky status bit
  // limitation: only byte lanes 0 and 1 reach the 16-bit registers

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [15:0] r3_ctrl; // reg3 control
    logic [15:0] r3_on; // reg3 on control
    logic [15:0] r3_sleep; // reg3 sleep control
    logic [15:0] r4_ctrl; // reg4 control
    logic [15:0] r4_on; // reg4 on control
    logic [15:0] r4_sleep; // reg4 sleep control
    logic [1:0] uv_seen; // sticky undervoltage seen bits
    logic aw_held; // address captured
    logic w_held; // data captured
    logic [15:0] aw_idx; // captured write index
    logic [31:0] wdata; // captured data
    logic [3:0] wstrb; // captured strobes
    logic bvalid; // write response pending
    logic [1:0] bresp; // write response code
    logic rvalid; // read data pending
    logic [31:0] rdata; // read data
    logic [1:0] rresp; // read response code
    logic shut3; // reg3 shutdown pulse
    logic shut4; // reg4 shutdown pulse
    logic dev_rst; // device reset pulse
    logic irq; // interrupt pulse
    logic r3_off; // registered reg3 off
    logic r3_lp; // registered reg3 low power
    logic [4:0] r3_v; // registered reg3 voltage
    logic r4_off; // registered reg4 off
    logic r4_lp; // registered reg4 low power
    logic [4:0] r4_v; // registered reg4 voltage
  } rsc_state_t;

  rsc_state_t st_reg; // current state
  rsc_state_t st_next; // next state

  // decoded outputs from the two regulator decoders
  logic h3_act, h4_act; // hw control active
  logic o3, o4, lp3, lp4; // off and low power
  logic [4:0] v3, v4; // voltage codes
  logic s3, s4, rr3, rr4, i3, i4; // event decodes

  // ****************************************
  // regulator decoders
  // ****************************************
  // reg3 own action field
  rsc_reg_side u_reg3 (
    .ctrl_word(st_reg.r3_ctrl),
    .on_word(st_reg.r3_on),
    .sleep_word(st_reg.r3_sleep),
    .in_sleep(in_sleep),
    .hwctl1(hwctl1),
    .hwctl2(hwctl2),
    .undervoltage(reg3_undervoltage),
    .seq(reg3_seq),
    .hw_active(h3_act),
    .reg_off(o3),
    .low_power(lp3),
    .voltage_code(v3),
    .shutdown_req(s3),
    .reset_req(rr3),
    .irq_event(i3)
  );

  // reg4 shares the field layout; its slot decode is not exported
  rsc_reg_side u_reg4 (
    .ctrl_word(st_reg.r4_ctrl),
    .on_word(st_reg.r4_on),
    .sleep_word(st_reg.r4_sleep),
    .in_sleep(in_sleep),
    .hwctl1(hwctl1),
    .hwctl2(hwctl2),
    .undervoltage(reg4_undervoltage),
    .seq(),
    .hw_active(h4_act),
    .reg_off(o4),
    .low_power(lp4),
    .voltage_code(v4),
    .shutdown_req(s4),
    .reset_req(rr4),
    .irq_event(i4)
  );

  // upper strobes are ignored: the registers are only 16 bits wide
  // read-only and reserved bits are forced to zero by the mask
  // merge a 16-bit register with strobes and mask
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s,
                                        input logic [15:0] m);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r & m;
  endfunction

  // ****************************************
  // next-state logic
  // ****************************************
  // one process computes the whole next state, so bus, event pulses
  // and applied settings never fight over a flop
  always_comb begin
    logic [15:0] ridx;
    logic hit;
    logic [15:0] rword;
    ridx = 16'h0000;
    hit = 1'b0;
    rword = 16'h0000;
    // hold everything unless a branch below changes it
    st_next = st_reg;
    // either half may come first; each is parked until its partner
    // capture write address and data independently
    if (s_axi_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_idx = s_axi_awaddr[RSC_ADDR_W-1:2];
    end
    if (s_axi_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
    end
    // commit once both halves are held and no response waits
    if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid) begin
      st_next.aw_held = 1'b0;
      st_next.w_held = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RSC_RESP_OKAY;
      case (st_reg.aw_idx)
        RSC_IDX_REG3_CTRL: st_next.r3_ctrl = merge(st_reg.r3_ctrl,
            st_reg.wdata, st_reg.wstrb, RSC_CTRL_MASK);
        RSC_IDX_REG3_ON: st_next.r3_on = merge(st_reg.r3_on,
            st_reg.wdata, st_reg.wstrb, RSC_ONSL_MASK);
        RSC_IDX_REG3_SLEEP: st_next.r3_sleep = merge(st_reg.r3_sleep,
            st_reg.wdata, st_reg.wstrb, RSC_ONSL_MASK);
        RSC_IDX_REG4_CTRL: st_next.r4_ctrl = merge(st_reg.r4_ctrl,
            st_reg.wdata, st_reg.wstrb, RSC_CTRL_MASK);
        RSC_IDX_REG4_ON: st_next.r4_on = merge(st_reg.r4_on,
            st_reg.wdata, st_reg.wstrb, RSC_ONSL_MASK);
        RSC_IDX_REG4_SLEEP: st_next.r4_sleep = merge(st_reg.r4_sleep,
            st_reg.wdata, st_reg.wstrb, RSC_ONSL_MASK);
        RSC_IDX_STATUS: begin
          // write one to clear sticky bits
          if (st_reg.wstrb[0]) begin
            st_next.uv_seen = st_reg.uv_seen & ~st_reg.wdata[1:0];
          end
        end
        // unmapped index: error response, nothing written
        default: st_next.bresp = RSC_RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // read: one cycle from address to data
    // arready stays low while data wait, holding off a second read
    if (s_axi_arvalid && !st_reg.rvalid) begin
      ridx = s_axi_araddr[RSC_ADDR_W-1:2];
      hit = 1'b1;
      case (ridx)
        RSC_IDX_REG3_CTRL: rword = st_reg.r3_ctrl;
        RSC_IDX_REG3_ON: rword = st_reg.r3_on;
        RSC_IDX_REG3_SLEEP: rword = st_reg.r3_sleep;
        RSC_IDX_REG4_CTRL: rword = st_reg.r4_ctrl;
        RSC_IDX_REG4_ON: rword = st_reg.r4_on;
        RSC_IDX_REG4_SLEEP: rword = st_reg.r4_sleep;
        RSC_IDX_STATUS: rword = {10'h000, h4_act, h3_act, 2'h0,
                                 st_reg.uv_seen};
        // unmapped read: zero data and an error response
        default: hit = 1'b0;
      endcase
      st_next.rvalid = 1'b1;
      st_next.rdata = {16'h0000, rword};
      st_next.rresp = hit ? RSC_RESP_OKAY : RSC_RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    // event side runs every cycle, whatever the bus is doing
    // both regulators share one interrupt; status tells them apart
    // sticky seen bits, set beats clear
    st_next.uv_seen = st_next.uv_seen | {i4, i3};
    st_next.irq = i3 | i4;
    st_next.shut3 = s3;
    st_next.shut4 = s4;
    st_next.dev_rst = rr3 | rr4;
    // one cycle of lag buys glitch-free control levels
    // registered applied settings
    st_next.r3_off = o3;
    st_next.r3_lp = lp3;
    st_next.r3_v = v3;
    st_next.r4_off = o4;
    st_next.r4_lp = lp4;
    st_next.r4_v = v4;
  end

  // state register
  // reset loads the register defaults and clears the rest, which
  // leaves all three ready outputs high straight out of reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.r3_ctrl <= RSC_CTRL_RST;
      st_reg.r3_on <= RSC_ON_RST;
      st_reg.r3_sleep <= RSC_SLEEP_RST;
      st_reg.r4_ctrl <= RSC_CTRL_RST;
      st_reg.r4_on <= RSC_ON_RST;
      st_reg.r4_sleep <= RSC_SLEEP_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // ready signals are combinational from the parked and read-pending flags; valid,
  // data and response codes come straight from flip-flops
  assign s_axi_awready = !st_reg.aw_held;
  assign s_axi_wready = !st_reg.w_held;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign reg3_lowpower_variant = st_reg.r3_ctrl[RSC_LP_BIT];
  assign reg3_output_float = st_reg.r3_ctrl[RSC_FLT_BIT];
  assign reg3_switch_mode = st_reg.r3_ctrl[RSC_SWI_BIT];
  assign reg3_off = st_reg.r3_off;
  assign reg3_low_power = st_reg.r3_lp;
  assign reg3_voltage = st_reg.r3_v;
  assign reg4_off = st_reg.r4_off;
  assign reg4_low_power = st_reg.r4_lp;
  assign reg4_voltage = st_reg.r4_v;
  assign reg_shutdown3 = st_reg.shut3;
  assign reg_shutdown4 = st_reg.shut4;
  assign device_reset_req = st_reg.dev_rst;
  assign undervoltage_irq = st_reg.irq;
  // reg3 decoded via own fields in u_reg3

endmodule

// ==== sim/rsc_regbank_asserts.sv ====
// checker for the regulator control register bank ports
// assumes it is bound onto rsc_regbank, one clock domain
`timescale 1ns/100ps
module rsc_regbank_asserts (
  input wire logic clk, // clock
  input wire logic rstn, // async reset, active low
  input wire logic hwctl1, // hw control input 1
  input wire logic hwctl2, // hw control input 2
  input wire logic reg3_undervoltage, // reg3 event pulse
  input wire logic reg4_undervoltage, // reg4 event pulse
  input wire rsc_pkg::rsc_seq_t reg3_seq, // slot decode
  input wire logic reg3_off, // reg3 forced off
  input wire logic reg_shutdown3, // reg3 shutdown pulse
  input wire logic reg_shutdown4, // reg4 shutdown pulse
  input wire logic device_reset_req, // device reset pulse
  input wire logic undervoltage_irq // interrupt pulse
);
  import rsc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****
  // event responses
  // ****
  // always interrupts
  property p_uv_irq;
    reg3_undervoltage || reg4_undervoltage |=> undervoltage_irq;
  endproperty
  a_uv_irq: assert property (p_uv_irq)
    else $error("event gave no interrupt");
  property p_irq_cause;
    undervoltage_irq |-> $past(reg3_undervoltage) || $past(reg4_undervoltage);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without event");
  property p_shut4;
    reg_shutdown4 |-> $past(reg4_undervoltage);
  endproperty
  a_shut4: assert property (p_shut4)
    else $error("reg4 shutdown without its event");
  property p_shut3;
    reg_shutdown3 |-> $past(reg3_undervoltage);
  endproperty
  a_shut3: assert property (p_shut3)
    else $error("reg3 shutdown without its event");
  property p_rst_irq;
    device_reset_req |-> undervoltage_irq
      && ($past(reg3_undervoltage) || $past(reg4_undervoltage));
  endproperty
  a_rst_irq: assert property (p_rst_irq)
    else $error("device reset without interrupt");
  // ****
  // slot decode
  // ****
  // hw enable 1 excludes the other two enable sources
  property p_hw_en;
    reg3_seq.hw_enable1 |-> !reg3_seq.hw_enable2 && !reg3_seq.enable_by_slot;
  endproperty
  a_hw_en: assert property (p_hw_en)
    else $error("enable sources overlap");
  property p_slot;
    reg3_seq.enable_by_slot |-> reg3_seq.enable_slot inside {[3'h1:3'h5]};
  endproperty
  a_slot: assert property (p_slot)
    else $error("startup slot out of range");
  property p_sleep_hw;
    reg3_seq.sleep_disable |-> !(reg3_seq.hw_enable1 || reg3_seq.hw_enable2)
      && reg3_seq.sleep_slot inside {[3'h1:3'h5]};
  endproperty
  a_sleep_hw: assert property (p_sleep_hw)
    else $error("sleep disable decode wrong");
  property p_off;
    $rose(reg3_off) |-> $past(hwctl1) || $past(hwctl2);
  endproperty
  a_off: assert property (p_off)
    else $error("reg3 off without hw control");
endmodule

// ==== sim/tb.sv ====
// self-checking bench for the regulator control register bank
// assumes rsc_regbank alone, driven over axi4-lite from here
`timescale 1ns/100ps
module tb;
  import rsc_pkg::*;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready; // bus
  logic awready, wready, bvalid, arready, rvalid; // bus answers
  logic [RSC_ADDR_W-1:0] awaddr, araddr; // byte addresses
  logic [31:0] wdata, rdata; // data words
  logic [3:0] wstrb; // byte lanes
  logic [1:0] bresp, rresp; // responses
  logic in_sleep, hwctl1, hwctl2, uv3, uv4, act; // side inputs
  rsc_seq_t seq; // slot decode
  logic r3_off, r3_lp, r3_var, r3_flt, r3_swi, r4_off, r4_lp; // status
  logic sh3, sh4, dev_rst, irq; // event pulses
  logic [4:0] r3_v, r4_v; // applied voltage codes
  int miscompares, checks_done; // tallies
  logic [15:0] idx_t [4] = '{RSC_IDX_REG3_CTRL, RSC_IDX_REG3_ON,
    RSC_IDX_REG3_SLEEP, RSC_IDX_REG4_CTRL}; // register indices
  logic [15:0] rst_t [4] = '{16'h0200, 16'h0000, 16'h0100, 16'h0200};
  logic [15:0] msk_t [4] = '{16'hdfc1, 16'he11f, 16'he11f, 16'hdfc1};
  logic [2:0] slp_t [8] = '{3'h5, 3'h5, 3'h4, 3'h3, 3'h2, 3'h1, 3'h3, 3'h1};

  rsc_regbank dut_u (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .in_sleep(in_sleep),
    .hwctl1(hwctl1), .hwctl2(hwctl2), .reg3_undervoltage(uv3),
    .reg4_undervoltage(uv4), .reg3_seq(seq), .reg3_off(r3_off),
    .reg3_low_power(r3_lp), .reg3_lowpower_variant(r3_var),
    .reg3_output_float(r3_flt), .reg3_switch_mode(r3_swi),
    .reg3_voltage(r3_v), .reg4_off(r4_off), .reg4_low_power(r4_lp),
    .reg4_voltage(r4_v), .reg_shutdown3(sh3), .reg_shutdown4(sh4),
    .device_reset_req(dev_rst), .undervoltage_irq(irq));

  // ****
  // clock, verdict, watchdog
  // ****
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // the tests need well under a thousand cycles; this is ample
  initial begin
    repeat (30000) @(posedge clk);
    miscompares++;
    final_report();
  end

  // ****
  // bus and compare tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [15:0] idx, input logic [15:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // only the watchdog ends a wait that never sees an answer
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [15:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("rdata", {16'h0000, e}, rdata);
    chk("rresp", er, rresp);
  endtask
  // outputs are registered, so let them settle before looking
  task automatic hw(input logic [1:0] h, input logic s);
    @(posedge clk);
    hwctl1 <= h[0];
    hwctl2 <= h[1];
    in_sleep <= s;
    repeat (3) @(posedge clk);
  endtask
  task automatic uv(input logic r, input logic [1:0] a);
    @(posedge clk);
    uv3 <= !r;
    uv4 <= r;
    @(posedge clk);
    uv3 <= 1'b0;
    uv4 <= 1'b0;
    #1;
    chk("irq", 1, irq);
    chk("shut", {r && a == 2'h1, !r && a == 2'h1}, {sh4, sh3});
    chk("devrst", a == 2'h2, dev_rst);
  endtask

  // ****
  // test sequence
  // ****
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {in_sleep, hwctl1, hwctl2, uv3, uv4} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++)
      rd(idx_t[i], rst_t[i], RSC_RESP_OKAY);
    chk("bits", 3'h0, {r3_var, r3_flt, r3_swi});
    for (int i = 0; i < 4; i++) begin
      wr(idx_t[i], 16'hffff, RSC_RESP_OKAY);
      rd(idx_t[i], msk_t[i], RSC_RESP_OKAY);
    end
    wr(16'h4080, 16'hffff, RSC_RESP_SLVERR);
    rd(16'h4080, 16'h0000, RSC_RESP_SLVERR);
    wr(RSC_IDX_REG3_CTRL, 16'h00c1, RSC_RESP_OKAY);
    chk("bits", 3'h7, {r3_var, r3_flt, r3_swi});
    // slot codes, with and without hw enable
    for (int h = 0; h < 2; h++)
      for (int c = 0; c < 8; c++) begin
        wr(RSC_IDX_REG3_ON, {(h ? 3'h6 : 3'(c)), 13'h0},
           RSC_RESP_OKAY);
        wr(RSC_IDX_REG3_SLEEP, {3'(c), 13'h0}, RSC_RESP_OKAY);
        chk("en", !h && c inside {[1:5]}, seq.enable_by_slot);
        if (!h && c inside {[1:5]}) chk("slot", c, seq.enable_slot);
        chk("hwen", {h || c == 6, !h && c == 7},
            {seq.hw_enable1, seq.hw_enable2});
        chk("sdis", !h && c inside {[1:5]},
            seq.sleep_disable);
        chk("sslot", slp_t[c], seq.sleep_slot);
      end
    // hw source table, hw mode off, sleep code under hw
    for (int r = 0; r < 2; r++) begin
      wr(r ? RSC_IDX_REG4_ON : RSC_IDX_REG3_ON, 16'h000a,
         RSC_RESP_OKAY);
      wr(r ? RSC_IDX_REG4_SLEEP : RSC_IDX_REG3_SLEEP, 16'h011c,
         RSC_RESP_OKAY);
      for (int s = 0; s < 4; s++) begin
        wr(idx_t[r * 3], {3'h0, 2'(s), 1'b1, 2'h1, 8'h00},
           RSC_RESP_OKAY);
        for (int h = 0; h < 4; h++) begin
          hw(2'(h), 1'b0);
          act = (s == 1 && h[0]) || (s == 2 && h[1]) || (s == 3 && h != 0);
          chk("off", act, r ? r4_off : r3_off);
          chk("volt", act ? 5'h1c : 5'h0a,
              r ? r4_v : r3_v);
        end
      end
    end
    // hw modes on reg3, sleep state underneath; reg4 follows sleep
    for (int m = 0; m < 4; m++) begin
      wr(RSC_IDX_REG3_CTRL, {6'h02, 2'(m), 8'h00}, RSC_RESP_OKAY);
      hw(2'h1, 1'b1);
      chk("off", m == 1, r3_off);
      if (m != 1) chk("lp", m != 3, r3_lp);
      chk("volt", 5'h0a, r3_v);
      hw(2'h0, 1'b1);
      chk("lp", 1, r3_lp);
      chk("lp4", 1, r4_lp);
      chk("volt", 5'h1c, r3_v);
      chk("volt4", 5'h1c, r4_v);
    end
    hw(2'h0, 1'b0);
    chk("lp", 0, r3_lp);
    chk("lp4", 0, r4_lp);
    chk("volt", 5'h0a, r3_v);
    // every error action on both regulators
    for (int r = 0; r < 2; r++)
      for (int a = 0; a < 4; a++) begin
        wr(idx_t[r * 3], {2'(a), 14'h0}, RSC_RESP_OKAY);
        uv(r[0], 2'(a));
      end
    // sticky status: both events seen, then write one to clear
    rd(RSC_IDX_STATUS, 16'h0003, RSC_RESP_OKAY);
    wr(RSC_IDX_STATUS, 16'h0003, RSC_RESP_OKAY);
    rd(RSC_IDX_STATUS, 16'h0000, RSC_RESP_OKAY);
    final_report();
  end
endmodule

bind rsc_regbank rsc_regbank_asserts chk_u (.clk(clk), .rstn(rstn),
  .hwctl1(hwctl1), .hwctl2(hwctl2), .reg3_undervoltage(reg3_undervoltage),
  .reg4_undervoltage(reg4_undervoltage), .reg3_seq(reg3_seq),
  .reg3_off(reg3_off), .reg_shutdown3(reg_shutdown3),
  .reg_shutdown4(reg_shutdown4), .device_reset_req(device_reset_req),
  .undervoltage_irq(undervoltage_irq));
